// *** logic/pmp_params.svh ***
// Constants for the program memory partition block
`ifndef PMP_PARAMS_SVH
`define PMP_PARAMS_SVH
`define PMP_PC_W 15
`define PMP_WORD_W 14
`define PMP_NV_ADDR_W 16
`define PMP_BYTE_W 8
`define PMP_MEM_WORDS 8192
`define PMP_LAST_ADDR 15'h1FFF
`define PMP_RESET_VEC 15'h0000
`define PMP_IRQ_VEC 15'h0004
`define PMP_PC_STEP 15'h0001
`define PMP_SAF_WORDS 15'h0080
`define PMP_BOOT_MIN 15'h0200
`define PMP_BSEL_W 3
`define PMP_PROG_HI 16'h7FFF
`define PMP_CFGW_LO 16'h8000
`define PMP_CFGW_HI 16'h80FF
`define PMP_INFO_LO 16'h8100
`define PMP_INFO_HI 16'h811F
`define PMP_TEMP_LOW_RANGE_CAL_LO 16'h8112
`define PMP_TEMP_HIGH_RANGE_CAL_LO 16'h8115
`define PMP_TEMP_HIGH_RANGE_CAL_HI 16'h8117
`define PMP_FVR_LO 16'h8118
`define PMP_FVR_HI 16'h811D
`define PMP_DCI_LO 16'h8200
`define PMP_DCI_HI 16'h821F
`define PMP_OFF_ERASE_ROW_SIZE 16'h8200
`define PMP_OFF_WRITE_LATCH_COUNT 16'h8201
`define PMP_OFF_USER_ROW_COUNT 16'h8202
`define PMP_OFF_EEPROM_SIZE 16'h8203
`define PMP_OFF_PIN_COUNT 16'h8204
`define PMP_VAL_ERASE_ROW_SIZE 14'h0020
`define PMP_VAL_WRITE_LATCH_COUNT 14'h0020
`define PMP_VAL_USER_ROW_COUNT 14'h0100
`define PMP_VAL_EEPROM_SIZE 14'h0100
`define PMP_VAL_PIN_COUNT 14'h0014
`define PMP_PROG_SEL 7
`endif

// *** logic/pmp_pkg.sv ***
// Types for the program memory partition block
package pmp_pkg;
  typedef enum logic [2:0] {
    PMP_REG_APP = 3'b000,
    PMP_REG_BOOT = 3'b001,
    PMP_REG_SAF = 3'b010,
    PMP_REG_CFGW = 3'b011,
    PMP_REG_INFO = 3'b100,
    PMP_REG_DCI = 3'b101,
    PMP_REG_NONE = 3'b110
  } pmp_region_t;
  typedef enum logic [0:0] {
    PMP_IND_IDLE = 1'b0,
    PMP_IND_WAIT = 1'b1
  } pmp_ind_state_t;
endpackage

// *** logic/pmp_top.sv ***
// Program memory map, partitioning, protection and read paths
// Functional notes
// - Words 8112h-8114h hold per-device low-range temperature ADC readings.
// - Words 8115h-8117h hold per-device high-range temperature ADC readings.
// - Temperature values are right-justified ADC results taken at 2.048V reference.
// - Words 8118h-811Dh hold measured ADC and comparator reference voltages in mV.
// - Read-only configuration table sits at 8200h-821Fh.
// - Table reports 32-word rows, 32 latches, 256 rows, 256-byte EEPROM, pins.
// - Writes or erases to information or configuration table change nothing.
// - Program counter is 15 bits over a 32K by 14-bit space.
// - Execution starts at 0000h after reset; interrupts go to 0004h.
// - Implemented memory is 8192 words, last address 1FFFh.
// - Pointer high bit 7 set makes indirect read return program word low byte.
// - Indirect writes aimed at program memory change nothing.
// - Indirect program memory read takes one extra cycle.
// - Both disable bits at 1 put all user flash in the application block.
// - Enabled boot block size comes from the size select field.
// - Clearing storage disable bit maps storage flash on the last 128 words.
// - Fetch from enabled storage flash is not valid execution.
// - Write to protected block leaves memory and sets write error flag.
// - Fetch outside valid area causes violation reset and clears violation flag.
`timescale 1ns/1ns
`include "pmp_params.svh"
module pmp_top
  import pmp_pkg::*;
#(
  parameter logic [13:0] TEMP_LO_CAL0 = 14'h0000, // Per-device trim word
  parameter logic [13:0] TEMP_LO_CAL1 = 14'h0000, // Per-device trim word
  parameter logic [13:0] TEMP_LO_CAL2 = 14'h0000, // Per-device trim word
  parameter logic [13:0] TEMP_HI_CAL0 = 14'h0000, // Per-device trim word
  parameter logic [13:0] TEMP_HI_CAL1 = 14'h0000, // Per-device trim word
  parameter logic [13:0] TEMP_HI_CAL2 = 14'h0000, // Per-device trim word
  parameter logic [13:0] REF_MV0 = 14'h0400, // adc_ref_1x_mv
  parameter logic [13:0] REF_MV1 = 14'h0800, // ADC 2x in mV
  parameter logic [13:0] REF_MV2 = 14'h1000, // ADC 4x in mV
  parameter logic [13:0] REF_MV3 = 14'h0400, // Comparator 1x in mV
  parameter logic [13:0] REF_MV4 = 14'h0800, // Comparator 2x in mV
  parameter logic [13:0] REF_MV5 = 14'h1000 // cmp_ref_4x_mv
) (
  input wire logic clk_i, // Core clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic boot_block_disable_n_i, // Low enables boot block
  input wire logic [`PMP_BSEL_W-1:0] boot_block_size_sel_i, // Boot size select
  input wire logic storage_area_disable_n_i, // Low enables storage flash
  input wire logic app_write_protect_i, // Protect application block
  input wire logic boot_write_protect_i, // Protect boot block
  input wire logic config_write_protect_i, // Protect configuration words
  input wire logic fetch_i, // Advance program counter
  input wire logic branch_i, // Load branch target
  input wire logic [`PMP_PC_W-1:0] branch_addr_i, // Branch target
  input wire logic irq_i, // Take interrupt vector
  output logic [`PMP_PC_W-1:0] pc_o, // Program counter
  output logic [`PMP_WORD_W-1:0] instr_o, // Fetched word
  output logic exec_violation_rst_o, // Violation reset pulse
  output logic exec_violation_flag_n_o, // Low after a violation
  input wire logic exec_flag_set_i, // Software sets flag back
  input wire logic [`PMP_NV_ADDR_W-1:0] ind_ptr_i, // Indirect pointer, high:low
  input wire logic ind_rd_i, // Indirect read request
  input wire logic ind_wr_i, // Indirect write request
  output logic ind_busy_o, // Extra read cycle in progress
  output logic ind_rvalid_o, // Indirect data valid
  output logic [`PMP_BYTE_W-1:0] ind_rdata_o, // Low byte of program word
  input wire logic [`PMP_NV_ADDR_W-1:0] nv_addr_i, // Controller address
  input wire logic [`PMP_WORD_W-1:0] nv_wdata_i, // Controller write data
  input wire logic nv_wr_i, // Controller write or erase
  input wire logic nv_rd_i, // Controller read
  output logic nv_rvalid_o, // Controller read data valid
  output logic [`PMP_WORD_W-1:0] nv_rdata_o, // Controller read data
  output logic write_error_flag_o, // Sticky write error
  input wire logic write_error_clr_i // Clear write error
);

  logic [`PMP_WORD_W-1:0] mem [`PMP_MEM_WORDS];
  logic [`PMP_PC_W-1:0] pc_reg;
  logic [`PMP_PC_W-1:0] pc_next;
  logic [`PMP_WORD_W-1:0] instr_reg;
  logic viol_rst_reg;
  logic viol_flag_n_reg;
  logic wr_err_reg;
  logic [`PMP_WORD_W-1:0] nv_rdata_reg;
  logic nv_rvalid_reg;
  logic [`PMP_BYTE_W-1:0] ind_rdata_reg;
  logic ind_rvalid_reg;
  logic [`PMP_PC_W-1:0] ind_addr_reg;
  pmp_ind_state_t ind_state_reg;
  pmp_region_t fetch_region;
  pmp_region_t nv_region;
  logic fetch_bad;
  logic nv_wr_ok;
  logic nv_wr_bad;

  // Last boot word; boot block always starts at zero
  function automatic logic [`PMP_PC_W-1:0] boot_last(input logic [`PMP_BSEL_W-1:0] sel);
    boot_last = (`PMP_BOOT_MIN << sel) - `PMP_PC_STEP;
  endfunction

  function automatic pmp_region_t region_of(input logic [`PMP_NV_ADDR_W-1:0] a);
    logic [`PMP_PC_W-1:0] pa;
    pa = a[`PMP_PC_W-1:0];
    if (a > `PMP_PROG_HI) begin
      if (a >= `PMP_CFGW_LO && a <= `PMP_CFGW_HI) region_of = PMP_REG_CFGW;
      else if (a >= `PMP_INFO_LO && a <= `PMP_INFO_HI) region_of = PMP_REG_INFO;
      else if (a >= `PMP_DCI_LO && a <= `PMP_DCI_HI) region_of = PMP_REG_DCI;
      else region_of = PMP_REG_NONE;
    end else if (pa > `PMP_LAST_ADDR) begin
      region_of = PMP_REG_NONE;
    end else if (!storage_area_disable_n_i && pa > `PMP_LAST_ADDR - `PMP_SAF_WORDS) begin
      region_of = PMP_REG_SAF;
    end else if (!boot_block_disable_n_i && pa <= boot_last(boot_block_size_sel_i)) begin
      region_of = PMP_REG_BOOT;
    end else begin
      region_of = PMP_REG_APP;
    end
  endfunction

  // Fixed factory words; anything unlisted reads zero
  function automatic logic [`PMP_WORD_W-1:0] info_word(input logic [`PMP_NV_ADDR_W-1:0] a);
    case (a)
      `PMP_TEMP_LOW_RANGE_CAL_LO: info_word = TEMP_LO_CAL0;
      `PMP_TEMP_LOW_RANGE_CAL_LO + 16'h0001: info_word = TEMP_LO_CAL1;
      `PMP_TEMP_LOW_RANGE_CAL_LO + 16'h0002: info_word = TEMP_LO_CAL2;
      `PMP_TEMP_HIGH_RANGE_CAL_LO: info_word = TEMP_HI_CAL0;
      `PMP_TEMP_HIGH_RANGE_CAL_LO + 16'h0001: info_word = TEMP_HI_CAL1;
      `PMP_TEMP_HIGH_RANGE_CAL_HI: info_word = TEMP_HI_CAL2;
      `PMP_FVR_LO: info_word = REF_MV0;
      `PMP_FVR_LO + 16'h0001: info_word = REF_MV1;
      `PMP_FVR_LO + 16'h0002: info_word = REF_MV2;
      `PMP_FVR_LO + 16'h0003: info_word = REF_MV3;
      `PMP_FVR_LO + 16'h0004: info_word = REF_MV4;
      `PMP_FVR_HI: info_word = REF_MV5;
      `PMP_OFF_ERASE_ROW_SIZE: info_word = `PMP_VAL_ERASE_ROW_SIZE;
      `PMP_OFF_WRITE_LATCH_COUNT: info_word = `PMP_VAL_WRITE_LATCH_COUNT;
      `PMP_OFF_USER_ROW_COUNT: info_word = `PMP_VAL_USER_ROW_COUNT;
      `PMP_OFF_EEPROM_SIZE: info_word = `PMP_VAL_EEPROM_SIZE;
      `PMP_OFF_PIN_COUNT: info_word = `PMP_VAL_PIN_COUNT;
      default: info_word = '0;
    endcase
  endfunction

  assign fetch_region = region_of({1'b0, pc_reg});
  assign nv_region = region_of(nv_addr_i);
  // Fetch from storage flash or unimplemented space is illegal
  assign fetch_bad = fetch_i && (fetch_region == PMP_REG_SAF || fetch_region == PMP_REG_NONE);
  // Storage flash has no protect bit of its own, so it always takes writes
  assign nv_wr_ok = nv_wr_i && ((nv_region == PMP_REG_APP && !app_write_protect_i) ||
    (nv_region == PMP_REG_BOOT && !boot_write_protect_i) || nv_region == PMP_REG_SAF);
  assign nv_wr_bad = nv_wr_i && ((nv_region == PMP_REG_APP && app_write_protect_i) ||
    (nv_region == PMP_REG_BOOT && boot_write_protect_i) ||
    (nv_region == PMP_REG_CFGW && config_write_protect_i));

  // Violation outranks interrupt, which outranks branch and step
  always_comb begin
    pc_next = pc_reg;
    if (fetch_bad) pc_next = `PMP_RESET_VEC;
    else if (irq_i) pc_next = `PMP_IRQ_VEC;
    else if (branch_i) pc_next = branch_addr_i;
    else if (fetch_i) pc_next = pc_reg + `PMP_PC_STEP;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pc_reg <= `PMP_RESET_VEC;
      instr_reg <= '0;
    end else begin
      pc_reg <= pc_next;
      if (fetch_i && !fetch_bad) instr_reg <= mem[pc_reg[`PMP_PC_W-3:0]];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      viol_rst_reg <= 1'b0;
      viol_flag_n_reg <= 1'b1;
    end else begin
      viol_rst_reg <= fetch_bad;
      // Violation beats a software set in the same cycle
      if (fetch_bad) viol_flag_n_reg <= 1'b0;
      else if (exec_flag_set_i) viol_flag_n_reg <= 1'b1;
    end
  end

  // Array has no reset; unwritten words read unknown
  // Only the controller path can write; info and table regions never reach here
  always_ff @(posedge clk_i) begin
    if (nv_wr_ok) mem[nv_addr_i[`PMP_PC_W-3:0]] <= nv_wdata_i;
  end

  // Sticky until cleared; an error in the clear cycle still lands
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wr_err_reg <= 1'b0;
    else if (nv_wr_bad) wr_err_reg <= 1'b1;
    else if (write_error_clr_i) wr_err_reg <= 1'b0;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nv_rvalid_reg <= 1'b0;
      nv_rdata_reg <= '0;
    end else begin
      nv_rvalid_reg <= nv_rd_i;
      if (nv_rd_i) begin
        case (nv_region)
          PMP_REG_APP, PMP_REG_BOOT, PMP_REG_SAF: nv_rdata_reg <= mem[nv_addr_i[`PMP_PC_W-3:0]];
          default: nv_rdata_reg <= info_word(nv_addr_i);
        endcase
      end
    end
  end

  // Indirect path: one wait cycle, then the low byte; writes are dropped
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ind_state_reg <= PMP_IND_IDLE;
      ind_addr_reg <= '0;
      ind_rvalid_reg <= 1'b0;
      ind_rdata_reg <= '0;
    end else begin
      ind_rvalid_reg <= 1'b0;
      case (ind_state_reg)
        PMP_IND_IDLE: begin
          if (ind_rd_i && ind_ptr_i[`PMP_PROG_SEL + `PMP_BYTE_W]) begin
            ind_addr_reg <= ind_ptr_i[`PMP_PC_W-1:0];
            ind_state_reg <= PMP_IND_WAIT;
          end
        end
        PMP_IND_WAIT: begin
          ind_rdata_reg <= (ind_addr_reg > `PMP_LAST_ADDR) ? '0 :
            mem[ind_addr_reg[`PMP_PC_W-3:0]][`PMP_BYTE_W-1:0];
          ind_rvalid_reg <= 1'b1;
          ind_state_reg <= PMP_IND_IDLE;
        end
        default: ind_state_reg <= PMP_IND_IDLE;
      endcase
    end
  end

  assign pc_o = pc_reg;
  assign instr_o = instr_reg;
  assign exec_violation_rst_o = viol_rst_reg;
  assign exec_violation_flag_n_o = viol_flag_n_reg;
  assign ind_busy_o = (ind_state_reg == PMP_IND_WAIT);
  assign ind_rvalid_o = ind_rvalid_reg;
  assign ind_rdata_o = ind_rdata_reg;
  assign nv_rvalid_o = nv_rvalid_reg;
  assign nv_rdata_o = nv_rdata_reg;
  assign write_error_flag_o = wr_err_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_irq_vector: assert property (irq_i && !fetch_bad |=> pc_o == `PMP_IRQ_VEC)
    else $error("interrupt did not vector");
  a_viol_reset: assert property (fetch_bad |=> exec_violation_rst_o && !exec_violation_flag_n_o && pc_o == '0)
    else $error("violation not reported");
  a_saf_fetch: assert property (fetch_i && !storage_area_disable_n_i
    && pc_o > `PMP_LAST_ADDR - `PMP_SAF_WORDS |=> exec_violation_rst_o)
    else $error("storage flash fetch allowed");
  a_app_default: assert property (boot_block_disable_n_i && storage_area_disable_n_i
    && nv_addr_i <= {1'b0, `PMP_LAST_ADDR} |-> nv_region == PMP_REG_APP)
    else $error("default partition not application");
  a_wr_error: assert property (nv_wr_bad |=> write_error_flag_o)
    else $error("protected write not flagged");
  a_ind_extra: assert property (ind_rd_i && ind_ptr_i[15] && !ind_busy_o |=> ind_busy_o ##1 ind_rvalid_o)
    else $error("indirect read timing wrong");
  a_ind_nodata: assert property (ind_rd_i && !ind_ptr_i[15] && !ind_busy_o |=> ##1 !ind_rvalid_o)
    else $error("data read taken as program read");
  a_dci_read: assert property (nv_rd_i && nv_addr_i == `PMP_OFF_USER_ROW_COUNT |=> nv_rdata_o == `PMP_VAL_USER_ROW_COUNT)
    else $error("row count table wrong");
  a_info_ro: assert property (nv_wr_i && (nv_region == PMP_REG_INFO || nv_region == PMP_REG_DCI) |-> !nv_wr_ok)
    else $error("read-only region writable");
  a_pc_step: assert property (fetch_i && !fetch_bad && !irq_i && !branch_i |=> pc_o == $past(pc_o) + `PMP_PC_STEP)
    else $error("program counter did not advance");

  // Partition decode, controller reads, sticky flags and dropped writes
  a_boot_range: assert property (!boot_block_disable_n_i && storage_area_disable_n_i
    && nv_addr_i <= {1'b0, `PMP_LAST_ADDR} && nv_addr_i <= {1'b0, boot_last(boot_block_size_sel_i)}
    |-> nv_region == PMP_REG_BOOT)
    else $error("boot block range wrong");
  a_saf_region: assert property (!storage_area_disable_n_i && nv_addr_i <= {1'b0, `PMP_LAST_ADDR}
    && nv_addr_i > {1'b0, `PMP_LAST_ADDR - `PMP_SAF_WORDS} |-> nv_region == PMP_REG_SAF)
    else $error("storage flash range wrong");
  a_table_rd: assert property (nv_rd_i && nv_addr_i == `PMP_OFF_ERASE_ROW_SIZE
    |=> nv_rdata_o == `PMP_VAL_ERASE_ROW_SIZE)
    else $error("erase row size wrong");
  a_nv_rvalid: assert property (nv_rd_i |=> nv_rvalid_o)
    else $error("controller read not answered");
  a_wr_err_hold: assert property (write_error_flag_o && !write_error_clr_i
    |=> write_error_flag_o)
    else $error("write error flag lost");
  a_viol_sticky: assert property (!exec_violation_flag_n_o && !exec_flag_set_i
    |=> !exec_violation_flag_n_o)
    else $error("violation flag lost");
  a_ind_wr_drop: assert property (ind_wr_i && !ind_rd_i && !ind_busy_o
    |=> !ind_busy_o && !ind_rvalid_o)
    else $error("indirect write started an access");

  c_irq: cover property (irq_i ##1 fetch_i);
  c_violation: cover property (fetch_bad ##1 exec_flag_set_i);
  c_ind_read: cover property (ind_rd_i ##2 ind_rvalid_o);
  c_wr_err: cover property (nv_wr_bad ##1 write_error_clr_i);
  c_saf_fetch: cover property (fetch_bad && fetch_region == PMP_REG_SAF);

endmodule // pmp_top

// *** tb/pmp_core_model.sv ***
// Core fetch path and programming tool model that issues requests to the block
`timescale 1ns/1ns
module pmp_core_model (
  input wire logic clk_i, // Core clock
  output logic fetch_o, // Fetch strobe
  output logic branch_o, // Branch strobe
  output logic irq_o, // Interrupt strobe
  output logic [14:0] baddr_o, // Branch target
  output logic ird_o, // Indirect read
  output logic iwr_o, // Indirect write
  output logic [15:0] ptr_o, // Indirect pointer
  output logic nvwr_o, // Controller write
  output logic nvrd_o, // Controller read
  output logic [15:0] nva_o, // Controller address
  output logic [13:0] nvd_o // Controller write data
);
  initial begin
    {fetch_o, branch_o, irq_o, ird_o, iwr_o, nvwr_o, nvrd_o} = '0;
    {baddr_o, ptr_o, nva_o, nvd_o} = '0;
  end
  // Strobes cover one edge; qualifiers are inverted afterwards so stale values never look valid
  task automatic core(input logic f, b, i, input logic [14:0] a);
    @(negedge clk_i);
    {fetch_o, branch_o, irq_o, baddr_o} = {f, b, i, a};
    @(negedge clk_i);
    {fetch_o, branch_o, irq_o, baddr_o} = {3'h0, ~a};
  endtask
  task automatic ind(input logic r, w, input logic [15:0] p);
    @(negedge clk_i);
    {ird_o, iwr_o, ptr_o} = {r, w, p};
    @(negedge clk_i);
    {ird_o, iwr_o, ptr_o} = {2'h0, ~p};
  endtask
  task automatic nv(input logic w, input logic [15:0] a, input logic [13:0] d);
    @(negedge clk_i);
    {nvwr_o, nvrd_o, nva_o, nvd_o} = {w, ~w, a, d};
    @(negedge clk_i);
    {nvwr_o, nvrd_o, nva_o, nvd_o} = {2'h0, ~a, ~d};
  endtask
endmodule // pmp_core_model

// *** tb/tb.sv ***
// Self-checking bench for the program memory partition block
`timescale 1ns/1ns
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic boot_block_disable_n_i = 1'b1;
  logic [2:0] boot_block_size_sel_i = 3'h0;
  logic storage_area_disable_n_i = 1'b1;
  logic app_write_protect_i = 1'b0;
  logic boot_write_protect_i = 1'b0;
  logic config_write_protect_i = 1'b0;
  logic exec_flag_set_i = 1'b0;
  logic write_error_clr_i = 1'b0;
  wire logic fetch_i, branch_i, irq_i, ind_rd_i, ind_wr_i, nv_wr_i, nv_rd_i;
  wire logic [14:0] branch_addr_i, pc_o;
  wire logic [15:0] ind_ptr_i, nv_addr_i;
  wire logic [13:0] nv_wdata_i, instr_o, nv_rdata_o;
  wire logic [7:0] ind_rdata_o;
  wire logic exec_violation_rst_o, exec_violation_flag_n_o, ind_busy_o, ind_rvalid_o;
  wire logic nv_rvalid_o, write_error_flag_o;
  int fails = 0;
  int num_checks = 0;
  // Distinct trim words so a swapped location shows up
  localparam logic [13:0] CAL_WORDS [12] = '{14'h0A01, 14'h0A02, 14'h0A03, 14'h0B01, 14'h0B02, 14'h0B03,
    14'h0401, 14'h0801, 14'h1001, 14'h0402, 14'h0802, 14'h1002};

  pmp_top #(.TEMP_LO_CAL0(CAL_WORDS[0]), .TEMP_LO_CAL1(CAL_WORDS[1]), .TEMP_LO_CAL2(CAL_WORDS[2]),
    .TEMP_HI_CAL0(CAL_WORDS[3]), .TEMP_HI_CAL1(CAL_WORDS[4]), .TEMP_HI_CAL2(CAL_WORDS[5]),
    .REF_MV0(CAL_WORDS[6]), .REF_MV1(CAL_WORDS[7]), .REF_MV2(CAL_WORDS[8]),
    .REF_MV3(CAL_WORDS[9]), .REF_MV4(CAL_WORDS[10]), .REF_MV5(CAL_WORDS[11])) pmp_top_inst (
    .clk_i, .sys_rst_i, .boot_block_disable_n_i, .boot_block_size_sel_i, .storage_area_disable_n_i,
    .app_write_protect_i, .boot_write_protect_i, .config_write_protect_i, .fetch_i, .branch_i,
    .branch_addr_i, .irq_i, .pc_o, .instr_o, .exec_violation_rst_o, .exec_violation_flag_n_o,
    .exec_flag_set_i, .ind_ptr_i, .ind_rd_i, .ind_wr_i, .ind_busy_o, .ind_rvalid_o, .ind_rdata_o,
    .nv_addr_i, .nv_wdata_i, .nv_wr_i, .nv_rd_i, .nv_rvalid_o, .nv_rdata_o, .write_error_flag_o,
    .write_error_clr_i);

  pmp_core_model pmp_core_model_inst (.clk_i(clk_i), .fetch_o(fetch_i), .branch_o(branch_i),
    .irq_o(irq_i), .baddr_o(branch_addr_i), .ird_o(ind_rd_i), .iwr_o(ind_wr_i), .ptr_o(ind_ptr_i),
    .nvwr_o(nv_wr_i), .nvrd_o(nv_rd_i), .nva_o(nv_addr_i), .nvd_o(nv_wdata_i));

  always #50 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic [13:0] e);
    pmp_core_model_inst.nv(1'b0, a, 14'h0000);
    chk(16'(nv_rvalid_o), 16'h0001);
    chk(16'(nv_rdata_o), 16'(e));
  endtask
  task automatic wr(input logic [15:0] a, input logic [13:0] d, input logic e);
    pmp_core_model_inst.nv(1'b1, a, d);
    chk(16'(write_error_flag_o), 16'(e));
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic ctl(input logic f, b, i, input logic [14:0] a);
    pmp_core_model_inst.core(f, b, i, a);
  endtask
  // Bounded wait: a missing violation pulse ends the run
  task automatic viol;
    int n;
    n = 0;
    while (exec_violation_rst_o !== 1'b1 && n < 4) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 4) begin
      chk(16'h0000, 16'h0001);
      wrap_up();
    end else begin
      chk(16'(pc_o), 16'h0000);
      chk(16'(exec_violation_flag_n_o), 16'h0000);
      @(negedge clk_i);
      chk(16'(exec_violation_rst_o), 16'h0000);
    end
  endtask

  task automatic t_table;
    logic [13:0] tbl [5];
    tbl = '{14'h0020, 14'h0020, 14'h0100, 14'h0100, 14'h0014};
    for (int i = 0; i < 12; i++) rd(16'h8112 + 16'(i), CAL_WORDS[i]);
    for (int i = 0; i < 5; i++) rd(16'h8200 + 16'(i), tbl[i]);
    wr(16'h8113, 14'h3FFF, 1'b0);
    wr(16'h8202, 14'h3FFF, 1'b0);
    rd(16'h8113, 14'h0A02);
    rd(16'h8202, 14'h0100);
    $display("test table done");
  endtask
  task automatic t_prot;
    wr(16'h0010, 14'h2ABC, 1'b0);
    rd(16'h0010, 14'h2ABC);
    app_write_protect_i = 1'b1;
    wr(16'h0010, 14'h1111, 1'b1);
    rd(16'h0010, 14'h2ABC);
    pulse(write_error_clr_i);
    chk(16'(write_error_flag_o), 16'h0000);
    app_write_protect_i = 1'b0;
    boot_write_protect_i = 1'b1;
    boot_block_disable_n_i = 1'b0;
    wr(16'h0300, 14'h1234, 1'b0);
    boot_block_size_sel_i = 3'h1;
    wr(16'h0300, 14'h0000, 1'b1);
    rd(16'h0300, 14'h1234);
    pulse(write_error_clr_i);
    boot_block_disable_n_i = 1'b1;
    wr(16'h0300, 14'h0000, 1'b0);
    config_write_protect_i = 1'b1;
    wr(16'h8007, 14'h0001, 1'b1);
    pulse(write_error_clr_i);
    $display("test protection done");
  endtask
  task automatic t_ind;
    pmp_core_model_inst.ind(1'b1, 1'b0, 16'h8010);
    chk(16'(ind_busy_o), 16'h0001);
    @(negedge clk_i);
    chk(16'(ind_rvalid_o), 16'h0001);
    chk(16'(ind_rdata_o), 16'h00BC);
    pmp_core_model_inst.ind(1'b0, 1'b1, 16'h8010);
    rd(16'h0010, 14'h2ABC);
    pmp_core_model_inst.ind(1'b1, 1'b0, 16'h0010);
    @(negedge clk_i);
    chk(16'(ind_rvalid_o), 16'h0000);
    $display("test indirect done");
  endtask
  task automatic t_fetch;
    ctl(1'b0, 1'b1, 1'b0, 15'h0010);
    ctl(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h0011);
    chk(16'(instr_o), 16'h2ABC);
    ctl(1'b0, 1'b1, 1'b0, 15'h7FFF);
    chk(16'(pc_o), 16'h7FFF);
    ctl(1'b0, 1'b1, 1'b0, 15'h1FFF);
    ctl(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h2000);
    chk(16'(exec_violation_rst_o), 16'h0000);
    ctl(1'b1, 1'b0, 1'b0, 15'h0000);
    viol();
    pulse(exec_flag_set_i);
    chk(16'(exec_violation_flag_n_o), 16'h0001);
    storage_area_disable_n_i = 1'b0;
    ctl(1'b0, 1'b1, 1'b0, 15'h1F7F);
    ctl(1'b1, 1'b0, 1'b0, 15'h0000);
    chk(16'(pc_o), 16'h1F80);
    chk(16'(exec_violation_rst_o), 16'h0000);
    ctl(1'b1, 1'b0, 1'b0, 15'h0000);
    viol();
    ctl(1'b0, 1'b0, 1'b1, 15'h0000);
    chk(16'(pc_o), 16'h0004);
    $display("test fetch done");
  endtask

  initial begin
    repeat (4) @(negedge clk_i);
    chk(16'(pc_o), 16'h0000);
    chk(16'(exec_violation_flag_n_o), 16'h0001);
    sys_rst_i = 1'b0;
    t_table();
    t_prot();
    t_ind();
    t_fetch();
    wrap_up();
  end
endmodule // tb
